// [logic/interlock_defs.vh]
// Constants for the safety interlock logic
// Function
// - HV relay needs closed chain and command
// - Door open or stage down drops HV
// - Door open removes shutter drive enable
// - Chain open and shutter not home: processor shuts lasers
// - Blue laser off when air flow stops
// - Chamber permit: chain closed, stand low
// - Each chamber solenoid needs permit and own command
// - Chamber vents when any interlock opens
// - Door open switches off climate control
// - Three indicators: power, scan, pressure
// - Two 32-character message panels driven
// - Two anode contacts redundant, third readable
// - Anode-up needs both slides and command
// - Cathode-up needs both slides and command
`ifndef INTERLOCK_DEFS_VH
`define INTERLOCK_DEFS_VH
`define SW_COUNT 12
`define SW_DOOR_A 0
`define SW_DOOR_B 1
`define SW_ANODE_UP_A 2
`define SW_ANODE_UP_B 3
`define SW_ANODE_UP_X 4
`define SW_CATH_UP 5
`define SW_STAND 6
`define SW_AIR_FLOW 7
`define SW_ANODE_SLIDE_A 8
`define SW_ANODE_SLIDE_B 9
`define SW_CATH_SLIDE_A 10
`define SW_CATH_SLIDE_B 11
`define SETTLE_CYCLES 2'h3
`define LCD_WIDTH 8
`endif

// [logic/sync2.v]
// Two-stage synchroniser for one switch input
`timescale 1ns/1ps
module sync2 (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Asynchronous level in, synchronised level out
    input wire din,
    output reg dout
);
    reg meta_reg;

    // First stage feeds only the second stage
    always @(posedge clock) begin
        if (rst) begin
            meta_reg <= 1'h0;
            dout <= 1'h0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

// [logic/safety_interlock_logic.v]
// Safety interlock gating for high voltage, shutter, chamber and stages
`timescale 1ns/1ps
`include "interlock_defs.vh"
module safety_interlock_logic (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Switch levels, 1 = contact closed (stand: 0 = lowered)
    input wire [`SW_COUNT-1:0] switches,
    input wire shutter_home,
    // Software commands
    input wire cmd_hv,
    input wire cmd_vent_close,
    input wire cmd_high_pressure,
    input wire cmd_low_pressure,
    input wire cmd_raise_anode,
    input wire cmd_raise_cathode,
    input wire cmd_laser_off,
    input wire cmd_scan,
    input wire cmd_power_led,
    // Message panel data from the processor
    input wire [`LCD_WIDTH-1:0] cathode_lcd_data_in,
    input wire cathode_lcd_strobe_in,
    input wire [`LCD_WIDTH-1:0] anode_lcd_data_in,
    input wire anode_lcd_strobe_in,
    // Relay and solenoid drives
    output reg hv_relay_on,
    output reg shutter_drive_on,
    output reg vent_solenoid_on,
    output reg high_pressure_solenoid_on,
    output reg low_pressure_solenoid_on,
    output reg anode_up_solenoid_on,
    output reg cathode_up_solenoid_on,
    output reg green_laser_on,
    output reg blue_laser_on,
    output reg climate_on,
    // Status back to the processor
    output reg door_open,
    output reg chain_closed,
    output reg chamber_permit,
    output reg anode_up_extra,
    output reg shutter_fault,
    // Indicators
    output reg led_power,
    output reg led_scan,
    output reg led_pressure,
    // Message panels
    output reg [`LCD_WIDTH-1:0] cathode_lcd_data,
    output reg cathode_lcd_strobe,
    output reg [`LCD_WIDTH-1:0] anode_lcd_data,
    output reg anode_lcd_strobe
);
    wire [`SW_COUNT-1:0] sw_sync;
    wire shutter_home_sync;
    reg [1:0] settle_reg;
    reg [1:0] settle_next;
    reg ready;
    reg door_ok;
    reg chain_ok;
    reg permit;

    ////////////////////////////////////////////////////////////////
    // Synchronisers on every switch input and on shutter_home
    genvar i;
    generate
        for (i = 0; i < `SW_COUNT; i = i + 1) begin : g_sync
            sync2 u_sync (
                .clock(clock),
                .rst(rst),
                .din(switches[i]),
                .dout(sw_sync[i])
            );
        end
    endgenerate

    sync2 u_sync_home (
        .clock(clock),
        .rst(rst),
        .din(shutter_home),
        .dout(shutter_home_sync)
    );

    ////////////////////////////////////////////////////////////////
    // Settle counter: relay, solenoid and laser drives stay off until synchronisers are filled
    always @* begin
        settle_next = settle_reg;
        if (settle_reg != `SETTLE_CYCLES) begin
            settle_next = settle_reg + 2'h1;
        end
        ready = (settle_reg == `SETTLE_CYCLES);
    end

    always @(posedge clock) begin
        if (rst) begin
            settle_reg <= 2'h0;
        end else begin
            settle_reg <= settle_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Interlock chain; series contacts, so any open one breaks it
    always @* begin
        door_ok = sw_sync[`SW_DOOR_A] & sw_sync[`SW_DOOR_B];
        // Both redundant anode contacts must close; third is status only
        chain_ok = door_ok & sw_sync[`SW_ANODE_UP_A] & sw_sync[`SW_ANODE_UP_B]
            & sw_sync[`SW_CATH_UP] & ready;
        permit = chain_ok & ~sw_sync[`SW_STAND];
    end

    ////////////////////////////////////////////////////////////////
    // High-voltage relay; any open series contact drops it on the third edge
    always @(posedge clock) begin
        if (rst) begin
            hv_relay_on <= 1'h0;
        end else begin
            hv_relay_on <= chain_ok & cmd_hv;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Shutter motor drive; unpowered, the spring pulls the shutter home
    always @(posedge clock) begin
        if (rst) begin
            shutter_drive_on <= 1'h0;
        end else begin
            shutter_drive_on <= door_ok & ready;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Chamber solenoids; de-energised means vented, so a lost permit
    // vents the chamber with no help from software
    always @(posedge clock) begin
        if (rst) begin
            vent_solenoid_on <= 1'h0;
            high_pressure_solenoid_on <= 1'h0;
            low_pressure_solenoid_on <= 1'h0;
        end else begin
            vent_solenoid_on <= permit & cmd_vent_close;
            high_pressure_solenoid_on <= permit & cmd_high_pressure;
            low_pressure_solenoid_on <= permit & cmd_low_pressure;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Stage lift solenoids; a slide not fully in blocks the lift
    always @(posedge clock) begin
        if (rst) begin
            anode_up_solenoid_on <= 1'h0;
            cathode_up_solenoid_on <= 1'h0;
        end else begin
            anode_up_solenoid_on <= ready & sw_sync[`SW_ANODE_SLIDE_A] & sw_sync[`SW_ANODE_SLIDE_B]
                & cmd_raise_anode;
            cathode_up_solenoid_on <= ready & sw_sync[`SW_CATH_SLIDE_A] & sw_sync[`SW_CATH_SLIDE_B]
                & cmd_raise_cathode;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Laser enables; a stuck shutter is the processor's to judge,
    // this block only obeys its shutdown command
    always @(posedge clock) begin
        if (rst) begin
            green_laser_on <= 1'h0;
            blue_laser_on <= 1'h0;
        end else begin
            green_laser_on <= ready & ~cmd_laser_off;
            blue_laser_on <= ready & ~cmd_laser_off & sw_sync[`SW_AIR_FLOW];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Compartment climate; off with the door open so that no hot air
    // blows at the operator
    always @(posedge clock) begin
        if (rst) begin
            climate_on <= 1'h0;
            door_open <= 1'h1;
        end else begin
            climate_on <= door_ok & ready;
            door_open <= ~door_ok;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status back to the processor for its position checks
    always @(posedge clock) begin
        if (rst) begin
            chain_closed <= 1'h0;
            chamber_permit <= 1'h0;
            anode_up_extra <= 1'h0;
            shutter_fault <= 1'h0;
        end else begin
            chain_closed <= chain_ok;
            chamber_permit <= permit;
            anode_up_extra <= sw_sync[`SW_ANODE_UP_X];
            shutter_fault <= ~chain_ok & ~shutter_home_sync;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Front-panel indicators; pressure lamp lags its solenoid one edge
    always @(posedge clock) begin
        if (rst) begin
            led_power <= 1'h0;
            led_scan <= 1'h0;
            led_pressure <= 1'h0;
        end else begin
            led_power <= cmd_power_led;
            led_scan <= cmd_scan;
            led_pressure <= high_pressure_solenoid_on;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Cathode message panel, retimed; character protocol is software's
    always @(posedge clock) begin
        if (rst) begin
            cathode_lcd_data <= {`LCD_WIDTH{1'h0}};
            cathode_lcd_strobe <= 1'h0;
        end else begin
            cathode_lcd_data <= cathode_lcd_data_in;
            cathode_lcd_strobe <= cathode_lcd_strobe_in;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Anode message panel, same one-edge retiming keeps both aligned
    always @(posedge clock) begin
        if (rst) begin
            anode_lcd_data <= {`LCD_WIDTH{1'h0}};
            anode_lcd_strobe <= 1'h0;
        end else begin
            anode_lcd_data <= anode_lcd_data_in;
            anode_lcd_strobe <= anode_lcd_strobe_in;
        end
    end
endmodule

// [verification/interlock_monitor.sv]
// Checker bound to the safety interlock top
`timescale 1ns/1ps
`include "interlock_defs.vh"
module interlock_monitor (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Inputs of the block
    input wire cmd_hv,
    input wire cmd_vent_close,
    input wire cmd_high_pressure,
    input wire cmd_raise_anode,
    input wire cmd_raise_cathode,
    input wire [`SW_COUNT-1:0] switches,
    // Outputs watched
    input wire hv_relay_on,
    input wire shutter_drive_on,
    input wire vent_solenoid_on,
    input wire high_pressure_solenoid_on,
    input wire climate_on,
    input wire anode_up_solenoid_on,
    input wire cathode_up_solenoid_on,
    input wire blue_laser_on,
    input wire door_open,
    input wire chain_closed,
    input wire chamber_permit
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Saturating age; pipelines hold only post-reset samples from 7 on
    logic [2:0] age;
    wire chain_in = switches[0] & switches[1] & switches[2] & switches[3] & switches[5];
    always @(posedge clock) age <= rst ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
    a_hv_needs_chain: assert property (hv_relay_on |-> chain_closed && $past(cmd_hv)) else $error("hv");
    a_open_drops_hv: assert property (age == 3'h7 && !$past(chain_in, 3) |-> !hv_relay_on)
        else $error("hv on open chain");
    a_door_stops: assert property (door_open |-> !shutter_drive_on && !climate_on) else $error("door");
    a_permit_exact: assert property (age == 3'h7 |-> chamber_permit == $past(chain_in && !switches[6], 3))
        else $error("permit");
    a_vent_gated: assert property (vent_solenoid_on |-> chamber_permit && $past(cmd_vent_close))
        else $error("vent");
    a_hp_exact: assert property (age == 3'h7
        |-> high_pressure_solenoid_on == (chamber_permit && $past(cmd_high_pressure))) else $error("hp");
    a_blue_air: assert property (blue_laser_on |-> $past(switches[7], 3)) else $error("blue");
    a_anode_slide: assert property (anode_up_solenoid_on |->
        $past(switches[8] && switches[9], 3) && $past(cmd_raise_anode)) else $error("anode up");
    a_cath_slide: assert property (cathode_up_solenoid_on |->
        $past(switches[10] && switches[11], 3) && $past(cmd_raise_cathode)) else $error("cathode up");
    a_settle_off: assert property ($fell(rst) |->
        (!hv_relay_on && !vent_solenoid_on) [*3]) else $error("settle");
    c_hv: cover property (hv_relay_on);
    c_door: cover property ($rose(door_open));
    c_drop: cover property ($fell(hv_relay_on));
    c_hp: cover property (high_pressure_solenoid_on);
endmodule
bind safety_interlock_logic interlock_monitor mon_u (.*);

// [verification/interlock_partner.sv]
// Switches and processor at the far side
`timescale 1ns/1ps
`include "interlock_defs.vh"
module interlock_partner (
    // Clock and wanted switch states
    input wire clock,
    input wire [`SW_COUNT-1:0] want_sw,
    input wire want_home,
    input wire shutter_fault,
    // Levels at the block
    output logic [`SW_COUNT-1:0] switches,
    output logic shutter_home,
    output logic cmd_laser_off = 1'h0
);
    // Contacts are asynchronous, so they follow at once
    assign switches = want_sw;
    assign shutter_home = want_home;
    // Processor answers a stuck shutter by killing lasers
    // Driven off the sampling edge, like every other block input
    always @(negedge clock) cmd_laser_off <= shutter_fault;
endmodule

// [verification/safety_interlock_logic_bench.sv]
// Self-checking bench for the safety interlock logic
`timescale 1ns/1ps
`include "interlock_defs.vh"
module safety_interlock_logic_bench;
    localparam logic [11:0] all_ok = 12'hFBF; // Contacts closed, stand lowered
    logic clock = 1'b0, rst = 1'b1, want_home = 1'b1, cathode_lcd_strobe_in, anode_lcd_strobe_in;
    logic cmd_hv, cmd_vent_close, cmd_high_pressure, cmd_low_pressure, cmd_raise_anode, cmd_raise_cathode;
    logic cmd_scan, cmd_power_led;
    logic [11:0] want_sw = 12'hFBF;
    logic [7:0] cathode_lcd_data_in, anode_lcd_data_in;
    wire hv_relay_on, shutter_drive_on, vent_solenoid_on, high_pressure_solenoid_on, low_pressure_solenoid_on;
    wire anode_up_solenoid_on, cathode_up_solenoid_on, green_laser_on, blue_laser_on, climate_on, door_open;
    wire chain_closed, chamber_permit, anode_up_extra, shutter_fault, led_power, led_scan, led_pressure;
    wire cathode_lcd_strobe, anode_lcd_strobe, shutter_home, cmd_laser_off;
    wire [7:0] cathode_lcd_data, anode_lcd_data;
    wire [`SW_COUNT-1:0] switches;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    safety_interlock_logic dut_u (.*);
    interlock_partner far_u (.*);
    initial forever #2.5 clock = ~clock;
    // Hang guard, far above the 68 cycles needed
    always @(posedge clock) if (++cycles == 3000) begin
        n_mismatch++;
        summarize();
    end
    task chk(input string name, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task go(input int n);
        repeat (n) @(negedge clock);
    endtask
    task summarize;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Door contact opens: exactly three edges to drop
    task t_door;
        {cmd_hv, cmd_vent_close} = 2'h3;
        go(1);
        chk("hv", 1, hv_relay_on);
        want_sw = all_ok & ~12'h001;
        go(2);
        chk("hv_hold", 1, hv_relay_on);
        go(1);
        chk("hv_drop", 0, hv_relay_on);
        chk("shutter", 0, shutter_drive_on);
        chk("climate", 0, climate_on);
        chk("vented", 0, vent_solenoid_on);
        chk("door_open", 1, door_open);
        chk("chain", 0, chain_closed);
        want_sw = all_ok;
        go(3);
        $display("door test done");
    endtask
    // One contact at a time: anode A, B, cathode, extra, stand
    task t_stage;
        int b[5];
        b = '{2, 3, 5, 4, 6};
        for (int i = 0; i < 5; i++) begin
            want_sw = all_ok ^ (12'h001 << b[i]);
            go(3);
            chk("hv_stage", i > 2, hv_relay_on);
            chk("permit", i == 3, chamber_permit);
            chk("vent", i == 3, vent_solenoid_on);
            chk("extra", i != 3, anode_up_extra);
            want_sw = all_ok;
            go(3);
        end
        $display("stage test done");
    endtask
    // Pressure, slides, lasers and panels
    task t_misc;
        {cmd_high_pressure, cmd_low_pressure, cmd_raise_anode, cmd_raise_cathode} = 4'hF;
        {cmd_scan, cmd_power_led, cathode_lcd_strobe_in, anode_lcd_strobe_in} = 4'hF;
        {cathode_lcd_data_in, anode_lcd_data_in} = 16'hA53C;
        go(1);
        chk("hp", 1, high_pressure_solenoid_on);
        chk("lp", 1, low_pressure_solenoid_on);
        chk("leds", 8'h3, {led_power, led_scan});
        chk("lcd_c", 8'hA5, cathode_lcd_data);
        chk("lcd_a", 8'h3C, anode_lcd_data);
        chk("strobes", 8'h3, {cathode_lcd_strobe, anode_lcd_strobe});
        want_sw = all_ok & ~12'h180;
        go(3);
        chk("lp_stand", 1, low_pressure_solenoid_on);
        chk("led_hp", 1, led_pressure);
        chk("lasers", 8'h1, {blue_laser_on, green_laser_on});
        chk("ups", 8'h1, {anode_up_solenoid_on, cathode_up_solenoid_on});
        want_sw = all_ok & ~12'h842;
        want_home = 1'b0;
        go(3);
        chk("press_off", 8'h0, {high_pressure_solenoid_on, low_pressure_solenoid_on});
        chk("ups2", 8'h2, {anode_up_solenoid_on, cathode_up_solenoid_on});
        go(2);
        chk("green_off", 0, green_laser_on);
        chk("blue_off", 0, blue_laser_on);
        chk("fault", 1, shutter_fault);
        chk("led_hp_off", 0, led_pressure);
        {want_home, want_sw} = {1'h1, all_ok};
        go(6);
        chk("lasers_back", 8'h3, {blue_laser_on, green_laser_on});
        $display("misc test done");
    endtask
    // Mid-run reset holds drives off through settling
    task t_reset;
        rst = 1'b1;
        go(2);
        chk("door_rst", 8'h2, {door_open, hv_relay_on});
        rst = 1'b0;
        go(3);
        chk("hv_settle", 0, hv_relay_on);
        go(3);
        chk("hv_back", 1, hv_relay_on);
        $display("reset test done");
    endtask
    initial begin
        {cmd_hv, cmd_vent_close, cmd_high_pressure, cmd_low_pressure, cmd_raise_anode} = '0;
        {cmd_raise_cathode, cmd_scan, cmd_power_led, cathode_lcd_strobe_in, anode_lcd_strobe_in} = '0;
        {cathode_lcd_data_in, anode_lcd_data_in} = '0;
        go(2);
        rst = 1'b0;
        go(6);
        t_door();
        t_stage();
        t_misc();
        t_reset();
        summarize();
    end
endmodule
